//--- verilog/cmh_pkg.sv
// Shared constants and types for the clocked microport handshake
`default_nettype none
package cmh_pkg;

  // Bus geometry
  localparam int CMH_DATA_W = 8;
  localparam int CMH_ADDR_W = 3;

  // Bus-style strap values
  localparam logic CMH_STYLE_SPLIT  = 1'h0;
  localparam logic CMH_STYLE_STROBE = 1'h1;

  // Direction line values in strobe/direction style
  localparam logic CMH_DIR_WRITE = 1'h0;
  localparam logic CMH_DIR_READ  = 1'h1;

  // Address of the internal register, whose reads take one extra cycle
  localparam logic [2:0] CMH_ADDR_INTERNAL = 3'h0;

  // Edges from access start (edge N) to ready/acknowledge
  localparam logic [1:0] CMH_LAT_READ_INT = 2'h3;
  localparam logic [1:0] CMH_LAT_READ     = 2'h2;
  localparam logic [1:0] CMH_LAT_WR_SPLIT = 2'h2;
  localparam logic [1:0] CMH_LAT_WR_STRB  = 2'h3;
  localparam logic [1:0] CMH_LAT_LAST     = 2'h1;

  // Reset values
  localparam logic [7:0] CMH_DATA_RST = 8'h00;
  localparam logic [2:0] CMH_ADDR_RST = 3'h0;

  // Device port states, Gray coded along idle-busy-hold
  typedef enum logic [1:0] {
    CMH_DEV_IDLE = 2'h0,
    CMH_DEV_BUSY = 2'h1,
    CMH_DEV_HOLD = 2'h3
  } cmh_dev_state_type;

  // Host states, Gray coded around the loop
  typedef enum logic [1:0] {
    CMH_HOST_IDLE = 2'h0,
    CMH_HOST_REQ  = 2'h1,
    CMH_HOST_WAIT = 2'h3,
    CMH_HOST_END  = 2'h2
  } cmh_host_state_type;

endpackage
`default_nettype wire

//--- verilog/cmh_bus_if.sv
// Pin-level carrier between the microprocessor and the port
`timescale 1ns/1ns
`default_nettype none
interface cmh_bus_if;
  import cmh_pkg::*;

  logic                  bus_style;
  logic                  cs_n;
  logic                  rd_or_data_strobe_n;
  logic                  wr_or_dir;
  logic [CMH_ADDR_W-1:0] addr;
  logic                  ready_or_transfer_ack_n;
  logic [CMH_DATA_W-1:0] host_data_out;
  logic                  host_data_oe_n;
  logic [CMH_DATA_W-1:0] dev_data_out;
  logic                  dev_data_oe_n;
  logic [CMH_DATA_W-1:0] data_bus;

  // Resolved data pins; an undriven bus reads as all ones (pull-ups)
  always_comb begin
    if (!dev_data_oe_n) begin
      data_bus = dev_data_out;
    end else if (!host_data_oe_n) begin
      data_bus = host_data_out;
    end else begin
      data_bus = {CMH_DATA_W{1'h1}};
    end
  end

  modport device (
    input  bus_style,
    input  cs_n,
    input  rd_or_data_strobe_n,
    input  wr_or_dir,
    input  addr,
    input  data_bus,
    output ready_or_transfer_ack_n,
    output dev_data_out,
    output dev_data_oe_n
  );

  modport host (
    input  bus_style,
    input  ready_or_transfer_ack_n,
    input  data_bus,
    output cs_n,
    output rd_or_data_strobe_n,
    output wr_or_dir,
    output addr,
    output host_data_out,
    output host_data_oe_n
  );

endinterface
`default_nettype wire

//--- verilog/cmh_device.sv
// Device end of the clocked microport: handshake and register access side
//
// Overview of operation
// - Strap low: split strobes, ready, clocked timing
// - Strap high: strobe, direction line, acknowledge
// - Split read: ready drops at once, returns N+3/N+2
// - Host may hold read strobes across reads
// - Host ends read by chip select high
// - Split write: ready drops at once, returns N+2
// - Host may hold write strobes across writes
// - Host ends write by chip select high
// - Next write waits for next start edge
// - Strobe read: acknowledge low N+3/N+2
// - Host may hold direction and strobe reading
// - Read completes on chip select high, acknowledge high
// - Strobe write: acknowledge low at N+3
// - Write completes on chip select high, acknowledge high
// - Three address bits, eight data bits, select
`timescale 1ns/1ns
`default_nettype none
module cmh_device
  import cmh_pkg::*;
#(
  parameter int DATA_W = CMH_DATA_W,
  parameter int ADDR_W = CMH_ADDR_W
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // Microport pins
  cmh_bus_if.device              bus,
  // Register file side
  output logic [ADDR_W-1:0]      o_reg_addr,
  output logic [DATA_W-1:0]      o_reg_wdata,
  output logic                   o_reg_we,
  output logic                   o_reg_re,
  input  wire logic [DATA_W-1:0] i_reg_rdata,
  // Status
  output logic                   o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (DATA_W != CMH_DATA_W || ADDR_W != CMH_ADDR_W) begin : g_bad_width
    $error("cmh_device serves only the eight-bit data, three-bit address pinout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  cmh_dev_state_type  state_q;
  logic [1:0]         count_q;
  logic               is_read_q;
  logic               ack_n_q;
  logic               busy_q;
  logic [DATA_W-1:0]  rdata_q;
  logic               drive_n_q;
  logic               req_read;
  logic               req_write;
  logic               req_any;
  logic [1:0]         latency_d;
  logic               split_ready;

  // Both styles are resolved from the live strap, so it must not move in use
  always_comb begin
    if (bus.bus_style == CMH_STYLE_STROBE) begin
      req_read  = !bus.cs_n && !bus.rd_or_data_strobe_n
                  && (bus.wr_or_dir == CMH_DIR_READ);
      req_write = !bus.cs_n && !bus.rd_or_data_strobe_n
                  && (bus.wr_or_dir == CMH_DIR_WRITE);
    end else begin
      req_read  = !bus.cs_n && !bus.rd_or_data_strobe_n;
      // Read wins when both split strobes are low, so no write pulse then
      req_write = !bus.cs_n && !bus.wr_or_dir && bus.rd_or_data_strobe_n;
    end
  end

  assign req_any = req_read || req_write;

  // Latency loaded at edge N; the port leaves busy when the count reaches one
  always_comb begin
    if (req_read) begin
      if (bus.addr == CMH_ADDR_INTERNAL) begin
        latency_d = CMH_LAT_READ_INT;
      end else begin
        latency_d = CMH_LAT_READ;
      end
    end else if (bus.bus_style == CMH_STYLE_STROBE) begin
      latency_d = CMH_LAT_WR_STRB;
    end else begin
      latency_d = CMH_LAT_WR_SPLIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= CMH_DEV_IDLE;
    end else begin
      case (state_q)
        CMH_DEV_IDLE: begin
          if (req_any) begin
            state_q <= CMH_DEV_BUSY;
          end
        end
        CMH_DEV_BUSY: begin
          if (count_q == CMH_LAT_LAST) begin
            state_q <= CMH_DEV_HOLD;
          end
        end
        CMH_DEV_HOLD: begin
          // Held strobes alone never restart; select must be seen high first
          if (bus.cs_n) begin
            state_q <= CMH_DEV_IDLE;
          end
        end
        default: begin
          state_q <= CMH_DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= 2'h0;
    end else if (state_q == CMH_DEV_IDLE && req_any) begin
      count_q <= latency_d;
    end else if (state_q == CMH_DEV_BUSY) begin
      count_q <= count_q - 2'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      is_read_q <= 1'h0;
    end else if (state_q == CMH_DEV_IDLE && req_any) begin
      is_read_q <= req_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register side strobes

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_addr  <= CMH_ADDR_RST;
      o_reg_wdata <= CMH_DATA_RST;
      o_reg_we    <= 1'h0;
      o_reg_re    <= 1'h0;
    end else begin
      o_reg_we <= (state_q == CMH_DEV_IDLE) && req_write;
      o_reg_re <= (state_q == CMH_DEV_IDLE) && req_read;
      if (state_q == CMH_DEV_IDLE && req_any) begin
        o_reg_addr  <= bus.addr;
        o_reg_wdata <= bus.data_bus;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= CMH_DATA_RST;
    end else if (state_q == CMH_DEV_BUSY && count_q == CMH_LAT_LAST && is_read_q) begin
      rdata_q <= i_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and data drivers

  // Registered busy; ready returns high on the edge that enters hold
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'h0;
    end else if (state_q == CMH_DEV_IDLE && req_any) begin
      busy_q <= 1'h1;
    end else if (state_q == CMH_DEV_BUSY && count_q == CMH_LAT_LAST) begin
      busy_q <= 1'h0;
    end
  end

  // Acknowledge low on entry to hold, high once select is sampled high
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_n_q <= 1'h1;
    end else if (state_q == CMH_DEV_BUSY && count_q == CMH_LAT_LAST) begin
      ack_n_q <= 1'h0;
    end else if (state_q == CMH_DEV_HOLD && bus.cs_n) begin
      ack_n_q <= 1'h1;
    end
  end

  // Data drive from hold entry of a read until select is seen high
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      drive_n_q <= 1'h1;
    end else if (state_q == CMH_DEV_BUSY && count_q == CMH_LAT_LAST && is_read_q) begin
      drive_n_q <= 1'h0;
    end else if (state_q == CMH_DEV_HOLD && bus.cs_n) begin
      drive_n_q <= 1'h1;
    end
  end

  // Combinational, as is the data drive enable: ready must fall before the next clock edge
  assign split_ready = !busy_q && !((state_q == CMH_DEV_IDLE) && req_any);

  always_comb begin
    if (bus.bus_style == CMH_STYLE_STROBE) begin
      bus.ready_or_transfer_ack_n = ack_n_q;
    end else begin
      bus.ready_or_transfer_ack_n = split_ready;
    end
  end

  // Drop the drive at once if select goes high, so the bus frees early
  assign bus.dev_data_oe_n = drive_n_q || bus.cs_n;
  assign bus.dev_data_out  = rdata_q;
  assign o_busy            = busy_q;

endmodule
`default_nettype wire

//--- verilog/cmh_host.sv
// Host end of the clocked microport: issues single reads and writes
`timescale 1ns/1ns
`default_nettype none
module cmh_host
  import cmh_pkg::*;
#(
  parameter int DATA_W = CMH_DATA_W,
  parameter int ADDR_W = CMH_ADDR_W
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // Microport pins
  cmh_bus_if.host                bus,
  // User command side
  input  wire logic              i_start,
  input  wire logic              i_write,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_done,
  output logic                   o_busy
);

  if (DATA_W != CMH_DATA_W || ADDR_W != CMH_ADDR_W) begin : g_bad_width
    $error("cmh_host serves only the eight-bit data, three-bit address pinout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  cmh_host_state_type state_q;
  logic               write_q;
  logic               finished;

  // Split style: ready back high; strobe style: acknowledge low
  assign finished = (bus.bus_style == CMH_STYLE_STROBE) ? !bus.ready_or_transfer_ack_n
                                                        : bus.ready_or_transfer_ack_n;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= CMH_HOST_IDLE;
    end else begin
      case (state_q)
        CMH_HOST_IDLE: begin
          if (i_start) begin
            state_q <= CMH_HOST_REQ;
          end
        end
        CMH_HOST_REQ: begin
          state_q <= CMH_HOST_WAIT;
        end
        CMH_HOST_WAIT: begin
          if (finished) begin
            state_q <= CMH_HOST_END;
          end
        end
        CMH_HOST_END: begin
          state_q <= CMH_HOST_IDLE;
        end
        default: begin
          state_q <= CMH_HOST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.cs_n                <= 1'h1;
      bus.rd_or_data_strobe_n <= 1'h1;
      bus.wr_or_dir           <= 1'h1;
      bus.addr                <= CMH_ADDR_RST;
      bus.host_data_out       <= CMH_DATA_RST;
      bus.host_data_oe_n      <= 1'h1;
      write_q                 <= 1'h0;
    end else if (state_q == CMH_HOST_IDLE && i_start) begin
      write_q                 <= i_write;
      bus.cs_n                <= 1'h0;
      bus.addr                <= i_addr;
      bus.host_data_out       <= i_wdata;
      bus.host_data_oe_n      <= !i_write;
      if (bus.bus_style == CMH_STYLE_STROBE) begin
        bus.rd_or_data_strobe_n <= 1'b0;
        bus.wr_or_dir           <= i_write ? CMH_DIR_WRITE : CMH_DIR_READ;
      end else begin
        bus.rd_or_data_strobe_n <= i_write;
        bus.wr_or_dir           <= !i_write;
      end
    end else if (state_q == CMH_HOST_WAIT && finished) begin
      // Only select and the data enable rise; strobes stay put, so a run of like accesses needs no re-strobe
      bus.cs_n                <= 1'h1;
      bus.host_data_oe_n      <= 1'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= CMH_DATA_RST;
      o_done  <= 1'h0;
    end else begin
      o_done <= (state_q == CMH_HOST_WAIT) && finished;
      if (state_q == CMH_HOST_WAIT && finished && !write_q) begin
        o_rdata <= bus.data_bus;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'h0;
    end else begin
      o_busy <= (state_q != CMH_HOST_IDLE) || i_start;
    end
  end

endmodule
`default_nettype wire

//--- tb/cmh_port_sva.sv
// Concurrent checks on the microport pins between host and device ends
`timescale 1ns/1ns
`default_nettype none
module cmh_port_sva
  import cmh_pkg::*;
(
  // Clock and reset
  input wire logic                  i_clock,
  input wire logic                  i_resetn,
  // Microport pins
  input wire logic                  bus_style,
  input wire logic                  cs_n,
  input wire logic                  rd_or_data_strobe_n,
  input wire logic                  wr_or_dir,
  input wire logic [CMH_ADDR_W-1:0] addr,
  input wire logic                  ready_or_transfer_ack_n,
  input wire logic                  dev_data_oe_n
);
  logic split;
  logic rdy;
  logic rd_req;
  logic wr_req;
  logic int_ad;

  assign split  = (bus_style == CMH_STYLE_SPLIT);
  assign rdy    = ready_or_transfer_ack_n;
  assign int_ad = (addr == CMH_ADDR_INTERNAL);
  // Read wins when both split strobes are low
  assign rd_req = split ? !rd_or_data_strobe_n : (!rd_or_data_strobe_n && wr_or_dir == CMH_DIR_READ);
  assign wr_req = split ? (rd_or_data_strobe_n && !wr_or_dir) : (!rd_or_data_strobe_n && wr_or_dir == CMH_DIR_WRITE);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////////////////////////////////////////
  a_split_rd_int: assert property (split && $fell(cs_n) && rd_req && int_ad |-> !rdy [*4] ##1 rdy)
    else $error("split internal read ready timing wrong");
  a_split_rd_ext: assert property (split && $fell(cs_n) && rd_req && !int_ad |-> !rdy [*3] ##1 rdy)
    else $error("split read ready timing wrong");
  a_split_wr_ret: assert property (split && $fell(cs_n) && wr_req |-> !rdy [*3] ##1 rdy)
    else $error("split write ready timing wrong");
  a_strb_ack_long: assert property (!split && $fell(cs_n) && (wr_req || rd_req && int_ad) |-> rdy [*4] ##1 !rdy)
    else $error("acknowledge late or early on long access");
  a_strb_ack_short: assert property (!split && $fell(cs_n) && rd_req && !int_ad |-> rdy [*3] ##1 !rdy)
    else $error("acknowledge timing wrong on read");
  a_ack_release: assert property (!split && !rdy && cs_n |=> rdy)
    else $error("acknowledge not forced high after select rose");
  a_ready_stands: assert property (split && !cs_n && !$past(cs_n) && $past(rdy) |-> rdy)
    else $error("ready fell while access held");
  a_drive_read_only: assert property (!dev_data_oe_n |-> !cs_n && !wr_req)
    else $error("data bus driven outside a selected read");
  a_read_drives: assert property ((split && $rose(rdy) || !split && $fell(rdy)) && rd_req && !cs_n |-> !dev_data_oe_n)
    else $error("read answered without data driven");
  a_reset_idle: assert property ($rose(i_resetn) |-> rdy && dev_data_oe_n)
    else $error("port not idle after reset");
  a_idle_ready: assert property (cs_n && $past(cs_n) |-> rdy)
    else $error("ready or acknowledge low with select high");

  c_split_read: cover property (split && $fell(cs_n) && rd_req && int_ad);
  c_strb_write: cover property (!split && $fell(cs_n) && wr_req);
  c_ack_done: cover property (!split && !rdy && cs_n);
  c_held_strobe: cover property (cs_n && !rd_or_data_strobe_n);
endmodule
`default_nettype wire

//--- tb/cmh_port_tb.sv
// Testbench joining host and device ends through the microport carrier
`timescale 1ns/1ns
`default_nettype none
module cmh_port_tb;
  import cmh_pkg::*;
  localparam int CYC_MAX = 3000;
  logic       clock;
  logic       resetn;
  logic       style;
  logic       start;
  logic       write;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] h_rdata;
  logic       h_done;
  logic       h_busy;
  logic [2:0] d_addr;
  logic [7:0] d_wdata;
  logic       d_we;
  logic       d_re;
  logic       d_busy;
  logic [7:0] reg_rdata;
  logic [7:0] mem [8];
  logic [7:0] shadow [8];
  logic [2:0] seen_addr;
  int         we_cnt;
  int         re_cnt;
  int         wait_cnt;
  int         cyc;
  int         err_total;
  int         n_compared;

  cmh_bus_if bus ();
  assign bus.bus_style = style;
  cmh_host u_cmh_host (.i_clock(clock), .i_resetn(resetn), .bus(bus), .i_start(start), .i_write(write),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(h_rdata), .o_done(h_done), .o_busy(h_busy));
  cmh_device u_cmh_device (.i_clock(clock), .i_resetn(resetn), .bus(bus), .o_reg_addr(d_addr),
    .o_reg_wdata(d_wdata), .o_reg_we(d_we), .o_reg_re(d_re), .i_reg_rdata(reg_rdata), .o_busy(d_busy));
  cmh_port_sva u_cmh_port_sva (.i_clock(clock), .i_resetn(resetn), .bus_style(bus.bus_style), .cs_n(bus.cs_n),
    .rd_or_data_strobe_n(bus.rd_or_data_strobe_n), .wr_or_dir(bus.wr_or_dir), .addr(bus.addr),
    .ready_or_transfer_ack_n(bus.ready_or_transfer_ack_n), .dev_data_oe_n(bus.dev_data_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // Register file behind the device, updated off the sampling edge
  always @(negedge clock) begin
    if (d_we) begin
      mem[d_addr] <= d_wdata;
      we_cnt++;
    end
    if (d_re) begin
      re_cnt++;
    end
    if (d_we || d_re) begin
      seen_addr <= d_addr;
    end
    reg_rdata <= mem[d_addr];
  end

  // Wait samples: select low while the port still holds the host off
  always @(posedge clock) begin
    cyc++;
    if (!bus.cs_n && (style ? bus.ready_or_transfer_ack_n : !bus.ready_or_transfer_ack_n)) begin
      wait_cnt++;
    end
    if (cyc == CYC_MAX) begin
      err_total++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One host access; latency counted on the pins, pulses on the register side
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    int we0;
    int re0;
    logic [7:0] lat;
    lat = ((!wr && a == CMH_ADDR_INTERNAL) || (wr && style)) ? 8'h04 : 8'h03;
    we0 = we_cnt;
    re0 = re_cnt;
    n = 0;
    while (h_busy !== 1'h0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    wait_cnt = 0;
    start = 1'h1;
    write = wr;
    addr = a;
    wdata = d;
    @(negedge clock);
    start = 1'h0;
    n = 0;
    while (h_done !== 1'h1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, h_done}, 8'h01);
    chk(wait_cnt[7:0], lat);
    chk(8'(we_cnt - we0), {7'h00, wr});
    chk(8'(re_cnt - re0), {7'h00, !wr});
    chk({5'h00, seen_addr}, {5'h00, a});
    if (wr) begin
      shadow[a] = d;
    end else begin
      chk(h_rdata, shadow[a]);
    end
    @(negedge clock);
    chk(bus.data_bus, 8'hFF);
    chk({7'h00, bus.ready_or_transfer_ack_n}, 8'h01);
    chk({7'h00, d_busy}, 8'h00);
    chk({6'h00, bus.rd_or_data_strobe_n, bus.wr_or_dir}, {6'h00, !style && wr, !wr});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    style = CMH_STYLE_SPLIT;
    start = 1'h0;
    write = 1'h0;
    addr = 3'h0;
    wdata = 8'h00;
    reg_rdata = 8'h00;
    for (int i = 0; i < 8; i++) begin
      mem[i] = 8'h00;
      shadow[i] = 8'h00;
    end
    repeat (4) @(negedge clock);
    resetn = 1'h1;
    chk({4'h0, bus.ready_or_transfer_ack_n, bus.dev_data_oe_n, h_busy, d_busy}, 8'h0C);
    for (int s = 0; s < 2; s++) begin
      style = s[0];
      for (int a = 0; a < 8; a++) begin
        xfer(1'h1, a[2:0], 8'(8'hA3 + 8'h11 * a + 8'h40 * s));
      end
      for (int a = 7; a >= 0; a--) begin
        xfer(1'h0, a[2:0], 8'h00);
      end
    end
    // Reset in mid-access must drop the transfer and leave the port idle
    start = 1'h1;
    write = 1'h0;
    addr = 3'h0;
    @(negedge clock);
    start = 1'h0;
    repeat (2) @(negedge clock);
    resetn = 1'h0;
    @(negedge clock);
    chk({4'h0, bus.ready_or_transfer_ack_n, bus.dev_data_oe_n, h_busy, d_busy}, 8'h0C);
    resetn = 1'h1;
    xfer(1'h0, 3'h5, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
